//--- verilog/acq_pkg.sv
// Behaviour
// - Single shot ends a delay-set number of samples after the trigger.
// - Pre-trigger delay may cover the whole record, up to one million points.
// - Post-trigger delay may start the record up to ten thousand divisions late; the code does not clamp it, dly_reg[30:0] counts samples.
// - Unpaired, all channels sample on one common clock instant, one converter each.
// - Slow timebases lower sample rate, keeping samples per record constant.
// - Interleaved mode measures sample-to-trigger offset to 5 ps and bins by it.
// - Interleaved capture needs at least 30 or 230 triggers, more if bins empty; single shot here re-arms until 230 (RIS_MIN_HI) in every case.
// - At 0.5 s/div or slower, samples stream to display until trigger completes.
// - Roll mode keeps acquiring; processing starts only on completed waveform.
// - Sequence mode splits memory into equal segments, one trigger each.
// - Each sequence segment records a 1 ns resolution trigger time stamp.
// - Segment spans ten divisions; sizes derive from segment count and memory.
// - Single sequence stops when all segments full, else waits for stop.
// - Normal sequence restarts from first segment on further triggers.
// - Auto sequence restarts when trigger interval exceeds the time-out.
// - Pairing on channel 2 or 3 doubles rate and record; 1 and 4 trigger only.
// - External sample clock allowed only when auxiliary input is not trigger.
// - External clock disables time stamps and auto time-out.
// - External clock counts scale and delay in samples per division, no phase.
// - External clock needs several pulses first; stops after trigger and count.
// - Any time-per-division change returns to internal clocking.
package acq_pkg;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_TDIV = 8'h04;
    localparam logic [7:0] ADDR_DLY = 8'h08;
    localparam logic [7:0] ADDR_SEGN = 8'h0C;
    localparam logic [7:0] ADDR_TOUT = 8'h10;
    localparam logic [7:0] ADDR_STAT = 8'h14;
    localparam logic [7:0] ADDR_TSTAMP = 8'h18;
    localparam logic [7:0] ADDR_PHASE = 8'h1C;
    localparam logic [7:0] ADDR_RISCNT = 8'h20;
    localparam logic [7:0] ADDR_CMD = 8'h24;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_RUN_LSB = 2;
    localparam int CTRL_PAIR_LSB = 4;
    localparam int CTRL_EXTCLK_BIT = 6;
    localparam int CTRL_AUXTRIG_BIT = 7;
    localparam int CTRL_SEQ_BIT = 8;
    localparam logic [31:0] TDIV_RESET = 32'h0000_0064;
    localparam logic [31:0] SEGN_RESET = 32'h0000_0001;
    localparam logic [31:0] TOUT_RESET = 32'h0000_4E20;
    localparam int RECORD_MAX = 1000000;
    localparam int POST_DIV_MAX = 10000;
    localparam int SEG_DIVS = 10;
    localparam int RIS_MIN_LO = 30;
    localparam int RIS_MIN_HI = 230;
    localparam int PHASE_RES_PS = 5;
    localparam int STAMP_RES_NS = 1;
    localparam int CLK_PERIOD_NS = 50;
    localparam int STAMP_STEP = CLK_PERIOD_NS / STAMP_RES_NS;
    localparam int ROLL_TDIV_MIN = 10000000;
    localparam int EXT_PULSES = 4;
    typedef enum logic [1:0] {MODE_SHOT = 2'b00, MODE_RIS = 2'b01, MODE_ROLL = 2'b11} acq_mode_t;
    typedef enum logic [1:0] {RUN_STOP = 2'b00, RUN_SINGLE = 2'b01, RUN_NORMAL = 2'b11,
        RUN_AUTO = 2'b10} acq_run_t;
    typedef enum logic [2:0] {ST_IDLE = 3'b000, ST_PRE = 3'b001, ST_ARMED = 3'b011,
        ST_POST = 3'b010, ST_DONE = 3'b110} acq_state_t;
    typedef struct packed {
        logic seq_on;
        logic aux_trig_sel;
        logic ext_clk_req;
        logic [1:0] pair;
        acq_run_t run;
        acq_mode_t mode;
    } acq_ctrl_t;
    typedef struct packed {
        logic [3:0] ext_present;
        logic roll;
        logic busy;
        logic wave_done;
        logic ext_active;
    } acq_stat_t;
endpackage

//--- verilog/acq_seq.sv
`timescale 1ns/10ps
`default_nettype none
module acq_seq #(
    parameter int SEG_MAX = 16,
    parameter int MEM_DEPTH = 2000000,
    parameter int FAST_RATE_DIV = 1
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic trig_in,
    input wire logic [15:0] trig_phase,
    input wire logic ext_clk_pulse,
    output logic sample_strobe,
    output logic [3:0] chan_enable,
    output logic [3:0] chan_trig_only,
    output logic [1:0] rate_mult,
    output logic [31:0] wr_addr,
    output logic stream_valid,
    output logic proc_start,
    output logic [15:0] bin_phase
);
    // ==========================================================
    // Register file
    // ==========================================================
    acq_pkg::acq_ctrl_t ctrl_reg;
    acq_pkg::acq_stat_t stat;
    logic [31:0] tdiv_reg, dly_reg, segn_reg, tout_reg, tstamp_reg, riscnt_reg;
    logic [31:0] stamp_ctr_reg, tout_ctr_reg, rate_ctr_reg, smp_ctr_reg, seg_idx_reg;
    logic [3:0] ext_cnt_reg;
    logic ext_active_reg, done_reg, stop_cmd, arm_cmd, tdiv_wr;
    logic aw_hold_reg, w_hold_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg, ws;
    acq_pkg::acq_state_t state_reg;
    logic tick, trig_ok, wr_fire;
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a <= acq_pkg::ADDR_CMD) && (a[1:0] == 2'b00);
    endfunction
    assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_hold_reg && !s_axi_bvalid;
    assign wr_fire = (aw_hold_reg || (s_axi_awvalid && s_axi_awready)) &&
        (w_hold_reg || (s_axi_wvalid && s_axi_wready)) && !s_axi_bvalid;
    logic [7:0] wa;
    logic [31:0] wd;
    assign wa = aw_hold_reg ? awaddr_reg : s_axi_awaddr;
    assign wd = w_hold_reg ? wdata_reg : s_axi_wdata;
    // Strobes travel with their held data, a late address must not see new ones
    assign ws = w_hold_reg ? wstrb_reg : s_axi_wstrb;
    assign tdiv_wr = wr_fire && wa == acq_pkg::ADDR_TDIV;
    assign stop_cmd = wr_fire && wa == acq_pkg::ADDR_CMD && wd[0];
    assign arm_cmd = wr_fire && wa == acq_pkg::ADDR_CMD && wd[1];
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            if (s_axi_awvalid && s_axi_awready && !wr_fire) begin
                aw_hold_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready && !wr_fire) begin
                w_hold_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(wa) ? 2'b00 : 2'b10;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ctrl_reg <= '0;
            tdiv_reg <= acq_pkg::TDIV_RESET;
            dly_reg <= 32'h0000_0000;
            segn_reg <= acq_pkg::SEGN_RESET;
            tout_reg <= acq_pkg::TOUT_RESET;
        end else begin
            if (wr_fire && ws == 4'hF) begin
                case (wa)
                    acq_pkg::ADDR_CTRL: begin
                        ctrl_reg <= wd[8:0];
                    end
                    acq_pkg::ADDR_TDIV: tdiv_reg <= wd;
                    acq_pkg::ADDR_DLY: dly_reg <= wd;
                    acq_pkg::ADDR_SEGN: segn_reg <= (wd == 32'h0000_0000) ? 32'h0000_0001 : wd;
                    acq_pkg::ADDR_TOUT: tout_reg <= wd;
                    default: ;
                endcase
            end
            if (tdiv_wr) begin
                ctrl_reg.ext_clk_req <= 1'b0;
            end
        end
    end
    assign stat = '{ext_present: ext_cnt_reg, roll: ctrl_reg.mode == acq_pkg::MODE_ROLL,
        busy: state_reg != acq_pkg::ST_IDLE, wave_done: done_reg, ext_active: ext_active_reg};
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
            case (s_axi_araddr)
                acq_pkg::ADDR_CTRL: s_axi_rdata <= {23'h0, ctrl_reg};
                acq_pkg::ADDR_TDIV: s_axi_rdata <= tdiv_reg;
                acq_pkg::ADDR_DLY: s_axi_rdata <= dly_reg;
                acq_pkg::ADDR_SEGN: s_axi_rdata <= segn_reg;
                acq_pkg::ADDR_TOUT: s_axi_rdata <= tout_reg;
                acq_pkg::ADDR_STAT: s_axi_rdata <= {seg_idx_reg[15:0], 8'h00, stat};
                acq_pkg::ADDR_TSTAMP: s_axi_rdata <= tstamp_reg;
                acq_pkg::ADDR_PHASE: s_axi_rdata <= {16'h0000, bin_phase};
                acq_pkg::ADDR_RISCNT: s_axi_rdata <= riscnt_reg;
                default: s_axi_rdata <= 32'h0000_0000;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    assign s_axi_arready = !s_axi_rvalid;
    // ==========================================================
    // Sample clock selection
    // ==========================================================
    // Several pulses seen before the outside clock counts as present
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !ctrl_reg.ext_clk_req || ctrl_reg.aux_trig_sel) begin
            ext_cnt_reg <= 4'h0;
            ext_active_reg <= 1'b0;
        end else if (ext_clk_pulse) begin
            if (ext_cnt_reg == 4'(acq_pkg::EXT_PULSES - 1)) begin
                ext_active_reg <= 1'b1;
            end else begin
                ext_cnt_reg <= ext_cnt_reg + 4'h1;
            end
        end
    end
    // Rate divider keeps samples per record fixed on slow settings
    logic [31:0] rate_div;
    assign rate_div = (tdiv_reg > 32'(FAST_RATE_DIV)) ? tdiv_reg : 32'(FAST_RATE_DIV);
    always_ff @(posedge sys_clk) begin
        if (sys_rst || rate_ctr_reg + 32'h1 >= rate_div) begin
            rate_ctr_reg <= 32'h0000_0000;
        end else begin
            rate_ctr_reg <= rate_ctr_reg + 32'h1;
        end
    end
    assign tick = ext_active_reg ? ext_clk_pulse : (rate_ctr_reg == 32'h0000_0000);
    assign sample_strobe = tick;
    // ==========================================================
    // Channel pairing
    // ==========================================================
    always_comb begin
        chan_enable = 4'hF;
        chan_trig_only = 4'h0;
        rate_mult = 2'd1;
        if (ctrl_reg.pair != 2'b00) begin
            chan_enable = (ctrl_reg.pair == 2'b01) ? 4'b0010 : 4'b0100;
            chan_trig_only = 4'b1001;
            rate_mult = 2'd2;
        end
    end
    // ==========================================================
    // Capture sequencer
    // ==========================================================
    logic [31:0] rec_len, seg_len, pre_len, post_len;
    assign rec_len = (ctrl_reg.pair != 2'b00) ? 32'(acq_pkg::RECORD_MAX * 2) : 32'(acq_pkg::RECORD_MAX);
    // Segment length with sequence on is memory depth divided by segment count, otherwise the record length
    assign seg_len = ctrl_reg.seq_on ? 32'(MEM_DEPTH) / segn_reg : rec_len;
    assign pre_len = dly_reg[31] ? 32'h0 : ((dly_reg > seg_len) ? seg_len : dly_reg);
    assign post_len = dly_reg[31] ? seg_len + {1'b0, dly_reg[30:0]} : seg_len - pre_len;
    assign trig_ok = trig_in && !(ctrl_reg.aux_trig_sel && ctrl_reg.ext_clk_req);
    logic seq_full, seq_restart, auto_to;
    assign seq_full = seg_idx_reg + 32'h1 >= segn_reg;
    assign auto_to = ctrl_reg.run == acq_pkg::RUN_AUTO && !ext_active_reg &&
        tout_ctr_reg >= tout_reg;
    assign seq_restart = arm_cmd || (auto_to && ctrl_reg.seq_on);
    always_ff @(posedge sys_clk) begin
        if (sys_rst || stop_cmd || ctrl_reg.run == acq_pkg::RUN_STOP) begin
            state_reg <= acq_pkg::ST_IDLE;
            smp_ctr_reg <= 32'h0;
            done_reg <= 1'b0;
        end else begin
            case (state_reg)
                acq_pkg::ST_IDLE: begin
                    if (arm_cmd) begin
                        state_reg <= acq_pkg::ST_PRE;
                        smp_ctr_reg <= 32'h0;
                        done_reg <= 1'b0;
                    end
                end
                acq_pkg::ST_PRE: begin
                    if (tick) begin
                        smp_ctr_reg <= smp_ctr_reg + 32'h1;
                    end
                    if (smp_ctr_reg >= pre_len) begin
                        state_reg <= acq_pkg::ST_ARMED;
                    end
                end
                acq_pkg::ST_ARMED: begin
                    if (trig_ok) begin
                        state_reg <= acq_pkg::ST_POST;
                        smp_ctr_reg <= 32'h0;
                    end
                end
                acq_pkg::ST_POST: begin
                    if (tick) begin
                        smp_ctr_reg <= smp_ctr_reg + 32'h1;
                    end
                    if (smp_ctr_reg >= post_len) begin
                        state_reg <= acq_pkg::ST_DONE;
                    end
                end
                acq_pkg::ST_DONE: begin
                    done_reg <= !ctrl_reg.seq_on || seq_full;
                    if (ctrl_reg.seq_on && !seq_full) begin
                        state_reg <= acq_pkg::ST_ARMED;
                    end else if (ctrl_reg.run != acq_pkg::RUN_SINGLE ||
                        (ctrl_reg.mode == acq_pkg::MODE_RIS &&
                        riscnt_reg < 32'(acq_pkg::RIS_MIN_HI))) begin
                        state_reg <= acq_pkg::ST_ARMED;
                    end else begin
                        state_reg <= acq_pkg::ST_IDLE;
                    end
                end
                default: state_reg <= acq_pkg::ST_IDLE;
            endcase
        end
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst || seq_restart) begin
            seg_idx_reg <= 32'h0;
        end else if (state_reg == acq_pkg::ST_DONE && ctrl_reg.seq_on) begin
            seg_idx_reg <= seq_full ? 32'h0 : seg_idx_reg + 32'h1;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst || state_reg == acq_pkg::ST_ARMED && trig_ok) begin
            tout_ctr_reg <= 32'h0;
        end else if (!auto_to) begin
            tout_ctr_reg <= tout_ctr_reg + 32'h1;
        end else begin
            tout_ctr_reg <= 32'h0;
        end
    end
    // Time stamp counter ticks in ns, one clock is several ns
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            stamp_ctr_reg <= 32'h0;
            tstamp_reg <= 32'h0;
        end else begin
            stamp_ctr_reg <= stamp_ctr_reg + 32'(acq_pkg::STAMP_STEP);
            if (state_reg == acq_pkg::ST_ARMED && trig_ok && ctrl_reg.seq_on && !ext_active_reg) begin
                tstamp_reg <= stamp_ctr_reg;
            end
        end
    end
    // Phase reported in 5 ps units; no phase taken on outside clock
    always_ff @(posedge sys_clk) begin
        if (sys_rst || arm_cmd) begin
            bin_phase <= 16'h0000;
            riscnt_reg <= 32'h0;
        end else if (state_reg == acq_pkg::ST_ARMED && trig_ok && ctrl_reg.mode == acq_pkg::MODE_RIS &&
            !ext_active_reg) begin
            bin_phase <= trig_phase;
            riscnt_reg <= riscnt_reg + 32'h1;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wr_addr <= 32'h0;
            stream_valid <= 1'b0;
            proc_start <= 1'b0;
        end else begin
            if (tick && state_reg != acq_pkg::ST_IDLE && state_reg != acq_pkg::ST_DONE) begin
                wr_addr <= seg_idx_reg * seg_len + (smp_ctr_reg % seg_len);
            end
            stream_valid <= tick && state_reg != acq_pkg::ST_IDLE &&
                tdiv_reg >= 32'(acq_pkg::ROLL_TDIV_MIN);
            proc_start <= state_reg == acq_pkg::ST_DONE;
        end
    end
    sample_done_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        state_reg == acq_pkg::ST_DONE |=> proc_start) else $error("no proc start");
    tdiv_int_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        tdiv_wr |=> !ctrl_reg.ext_clk_req) else $error("ext clock kept");
    pair_trig_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ctrl_reg.pair != 2'b00 |-> rate_mult == 2'd2 && chan_trig_only == 4'b1001)
        else $error("pairing wrong");
    ext_sel_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ctrl_reg.aux_trig_sel |=> !ext_active_reg) else $error("ext clock with aux trig");
    seg_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        arm_cmd |=> seg_idx_reg == 32'h0) else $error("segment not cleared");
    stop_idle_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        stop_cmd |=> state_reg == acq_pkg::ST_IDLE) else $error("stop ignored");
    trig_post_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        state_reg == acq_pkg::ST_ARMED && trig_ok && !stop_cmd && ctrl_reg.run != acq_pkg::RUN_STOP
        |=> state_reg == acq_pkg::ST_POST) else $error("trigger missed");
    stamp_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ext_active_reg |=> $stable(tstamp_reg)) else $error("stamp on ext clock");
endmodule
`default_nettype wire

//--- dv/acq_src_model.sv
`timescale 1ns/10ps
`default_nettype none
// ========================================
// Trigger source and outside sample clock
module acq_src_model (
    input wire logic sys_clk,
    input wire logic fire,
    input wire logic [15:0] phase_req,
    input wire logic tick,
    output logic trig_in,
    output logic [15:0] trig_phase,
    output logic ext_clk_pulse
);
    initial begin
        trig_in = 1'b0;
        trig_phase = 16'h0000;
        ext_clk_pulse = 1'b0;
    end
    // Phase only meaningful with a trigger; toggles otherwise so stale values never match
    always @(posedge sys_clk) begin
        trig_in <= fire;
        trig_phase <= fire ? phase_req : ~trig_phase;
        ext_clk_pulse <= tick;
    end
endmodule
`default_nettype wire

//--- dv/acquisition_sequencer_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module acquisition_sequencer_tb_top;
    // ========================================
    // Signals
    logic sys_clk = 1'b0, sys_rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rate_mult;
    logic [31:0] s_axi_rdata, wr_addr;
    logic trig_in, ext_clk_pulse, sample_strobe, stream_valid, proc_start;
    logic [15:0] trig_phase, bin_phase;
    logic [3:0] chan_enable, chan_trig_only;
    logic fire = 1'b0, tick = 1'b0;
    logic [15:0] phase_req = 16'h0000;
    integer seed = 32'hc288;
    int fails = 0, n_compared = 0, cyc = 0, n_proc = 0, n_strobe = 0, n_stream = 0;
    logic [31:0] d;

    always #25 sys_clk = ~sys_clk;

    // Small memory keeps each segment short
    acq_seq #(.MEM_DEPTH(64)) u_dut (.sys_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .trig_in, .trig_phase, .ext_clk_pulse, .sample_strobe, .chan_enable,
        .chan_trig_only, .rate_mult, .wr_addr, .stream_valid, .proc_start, .bin_phase);
    acq_src_model u_src (.sys_clk, .fire, .phase_req, .tick, .trig_in, .trig_phase, .ext_clk_pulse);

    // ========================================
    // Checking and bus tasks
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (proc_start === 1'b1) n_proc++;
        if (cyc == 20000) begin
            fails++;
            report_and_stop;
        end
    end
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid || s_axi_wvalid);
        while (s_axi_bvalid !== 1'b1) @(posedge sys_clk);
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, s_axi_bresp}, 32'h0000_0000);
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(nm, s_axi_rdata, e);
        chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
    endtask
    // Reading a single status bit through the full word would hide other fields changing
    task automatic sbit(input string nm, input int b, input logic e);
        @(posedge sys_clk);
        s_axi_araddr <= acq_pkg::ADDR_STAT;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(nm, {31'h0, s_axi_rdata[b]}, {31'h0, e});
    endtask
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            tick <= 1'b1;
            @(posedge sys_clk);
            tick <= 1'b0;
        end
    endtask
    task automatic trig(input logic [15:0] p);
        @(posedge sys_clk);
        fire <= 1'b1;
        phase_req <= p;
        @(posedge sys_clk);
        fire <= 1'b0;
    endtask
    function automatic logic [31:0] exp_rate(input int p);
        return (p != 0) ? 32'h0000_0002 : 32'h0000_0001;
    endfunction
    function automatic logic [31:0] exp_trig(input int p);
        return (p != 0) ? 32'h0000_0009 : 32'h0000_0000;
    endfunction

    // ========================================
    // Scenarios
    initial begin
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        chk("chan_enable", {28'h0, chan_enable}, 32'h0000_000F);
        chk("rate_mult", {30'h0, rate_mult}, 32'h0000_0001);
        rchk("tdiv", acq_pkg::ADDR_TDIV, acq_pkg::TDIV_RESET, 2'b00);
        rchk("segn", acq_pkg::ADDR_SEGN, acq_pkg::SEGN_RESET, 2'b00);
        rchk("tout", acq_pkg::ADDR_TOUT, acq_pkg::TOUT_RESET, 2'b00);
        rchk("unmapped", 8'h40, 32'h0000_0000, 2'b10);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            d = $random(seed);
            wr(acq_pkg::ADDR_TOUT, d);
            rchk("tout", acq_pkg::ADDR_TOUT, d, 2'b00);
        end
        wr(acq_pkg::ADDR_SEGN, 32'h0000_0000);
        rchk("segn zero", acq_pkg::ADDR_SEGN, 32'h0000_0001, 2'b00);
        $display("test registers done");
        for (int p = 0; p < 4; p++) begin
            wr(acq_pkg::ADDR_CTRL, 32'(p) << acq_pkg::CTRL_PAIR_LSB);
            chk("rate_mult", {30'h0, rate_mult}, exp_rate(p));
            chk("trig_only", {28'h0, chan_trig_only}, exp_trig(p));
            chk("chan_enable", {28'h0, chan_enable}, (p == 0) ? 32'h0000_000F : (p == 1) ? 32'h0000_0002 : 32'h0000_0004);
        end
        $display("test pairing done");
        wr(acq_pkg::ADDR_CTRL, 32'h0000_0040);
        pulses(acq_pkg::EXT_PULSES - 1);
        sbit("ext early", 0, 1'b0);
        pulses(1);
        sbit("ext on", 0, 1'b1);
        wr(acq_pkg::ADDR_TDIV, 32'h0000_0001);
        sbit("ext off", 0, 1'b0);
        wr(acq_pkg::ADDR_CTRL, 32'h0000_00C0);
        pulses(8);
        sbit("ext aux", 0, 1'b0);
        $display("test external clock done");
        wr(acq_pkg::ADDR_CTRL, 32'h0000_0104);
        wr(acq_pkg::ADDR_SEGN, 32'h0000_0002);
        wr(acq_pkg::ADDR_DLY, 32'h8000_0004);
        wr(acq_pkg::ADDR_CMD, 32'h0000_0002);
        repeat (100) @(posedge sys_clk);
        trig(16'($random(seed)));
        repeat (400) @(posedge sys_clk);
        sbit("seq waiting", 2, 1'b1);
        chk("wr_addr seg", {31'h0, wr_addr >= 32'h0000_0020 && wr_addr < 32'h0000_0040}, 32'h0000_0001);
        wr(acq_pkg::ADDR_CMD, 32'h0000_0001);
        sbit("seq stopped", 2, 1'b0);
        wr(acq_pkg::ADDR_CMD, 32'h0000_0002);
        repeat (2) begin
            repeat (100) @(posedge sys_clk);
            trig(16'($random(seed)));
        end
        repeat (400) @(posedge sys_clk);
        sbit("seq done", 1, 1'b1);
        sbit("seq idle", 2, 1'b0);
        chk("proc_start", {31'h0, n_proc != 0}, 32'h0000_0001);
        $display("test sequence done");
        wr(acq_pkg::ADDR_CTRL, 32'h0000_0005);
        wr(acq_pkg::ADDR_CMD, 32'h0000_0002);
        repeat (100) @(posedge sys_clk);
        d = $random(seed);
        trig(d[15:0]);
        repeat (20) @(posedge sys_clk);
        chk("bin_phase", {16'h0, bin_phase}, {16'h0, d[15:0]});
        rchk("riscnt", acq_pkg::ADDR_RISCNT, 32'h0000_0001, 2'b00);
        $display("test interleaved done");
        wr(acq_pkg::ADDR_TDIV, 32'h0000_0004);
        repeat (40) begin
            @(posedge sys_clk);
            if (sample_strobe === 1'b1) n_strobe++;
            if (stream_valid === 1'b1) n_stream++;
        end
        chk("strobes", 32'(n_strobe), 32'h0000_000A);
        chk("stream", 32'(n_stream), 32'h0000_0000);
        $display("test sample rate done");
        report_and_stop;
    end
endmodule
`default_nettype wire
